// file: core/cfm_pkg.sv
// shared constants, register map and types of the clock fault monitor
package cfm_pkg;
  localparam int NUM_IN    = 4;
  localparam int NUM_PLL   = 4;
  localparam int NUM_DEF   = 8;
  localparam int NUM_ALARM = 4;
  localparam int ADDR_W    = 7;

  // register byte offsets
  localparam logic [6:0] OFS_STATUS    = 7'h00;
  localparam logic [6:0] OFS_NOTIFY    = 7'h04;
  localparam logic [6:0] OFS_NOTIFY_EN = 7'h08;
  localparam logic [6:0] OFS_INT_MASK  = 7'h0c;
  localparam logic [6:0] OFS_LOSS_CFG  = 7'h10;
  localparam logic [6:0] OFS_DRIFT_CFG = 7'h20;
  localparam logic [6:0] OFS_ALM_CFG   = 7'h30;
  localparam logic [6:0] OFS_SEL       = 7'h40;

  // defect bit positions in status, notify, enable and mask
  localparam int DEF_LOSS_LSB  = 0;
  localparam int DEF_DRIFT_LSB = 4;

  // missing-edge detector word fields
  localparam int LOSS_PERIOD_LSB = 0;
  localparam int LOSS_SET_LSB    = 16;
  localparam int LOSS_CLR_LSB    = 24;
  localparam int LOSS_VAL_LSB    = 30;
  // drift detector word fields
  localparam int DRIFT_SET_LSB    = 0;
  localparam int DRIFT_CLR_LSB    = 4;
  localparam int DRIFT_SETTLE_LSB = 6;
  localparam int DRIFT_PRIO_LSB   = 22;
  // alarm pin and selection word fields
  localparam int ALM_MASK_LSB  = 0;
  localparam int ALM_SEL_LSB   = 8;
  localparam int ALM_OR_BIT    = 11;
  localparam int ALM_LIVE_BIT  = 12;
  localparam int SEL_VALID_LSB = 8;

  // writable bits and reset values
  localparam logic [31:0] LOSS_CFG_WMASK  = 32'hffffffff;
  localparam logic [31:0] DRIFT_CFG_WMASK = 32'h3fffffff;
  localparam logic [31:0] ALM_WMASK       = 32'h00001fff;
  localparam logic [31:0] LOSS_CFG_RST    = 32'h02040040;
  localparam logic [31:0] DRIFT_CFG_RST   = 32'h390002b9;
  localparam logic [31:0] ALM_RST         = 32'h00000000;
  localparam logic [7:0]  DEF_RST         = 8'h00;

  // timing: one housekeeping tick per millisecond
  localparam int CLK_MHZ  = 200;
  localparam int TICK_US  = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam logic [9:0] VAL_MS [4] = '{10'd2, 10'd100, 10'd200, 10'd1000};

  // drift thresholds in tenths of a ppm
  localparam logic [63:0] PPM_SCALE = 64'd10000000;
  localparam logic [15:0] SET_DPPM [10] = '{16'd2, 16'd4, 16'd20, 16'd40,
    16'd200, 16'd400, 16'd2000, 16'd4000, 16'd20000, 16'd40000};
  localparam logic [15:0] CLR_DPPM [4] = '{16'd2, 16'd4, 16'd20, 16'd2000};

  typedef enum logic [1:0] {
    CLK_OK = 2'b00, CLK_LOST = 2'b01, CLK_QUAL = 2'b11
  } cfm_clk_e;
  typedef enum logic [1:0] {
    LK_OK = 2'b00, LK_LOST = 2'b01, LK_SETTLE = 2'b11
  } cfm_lock_e;
endpackage : cfm_pkg

// file: core/cfm_loss_if.sv
// settings and result of one missing-edge detector
`timescale 1ns/1ps
`default_nettype none
interface cfm_loss_if;
  logic [15:0] period;    // expected input period in clock cycles
  logic [7:0]  setCnt;    // missing edges that declare loss
  logic [5:0]  clrCnt;    // missing edges that spoil recovery
  logic [1:0]  valSel;    // qualification time select
  logic        edgeSeen;  // synchronised rising edge
  logic        lost;      // live loss status
  modport det (input period, setCnt, clrCnt, valSel, edgeSeen, output lost);
  modport ctl (output period, setCnt, clrCnt, valSel, edgeSeen, input lost);
endinterface : cfm_loss_if
`default_nettype wire

// file: core/cfm_loss_det.sv
// missing-edge clock loss detector for one input
`timescale 1ns/1ps
`default_nettype none
module cfm_loss_det (
  input  wire logic ref_clk,  // reference clock
  input  wire logic rst,      // async reset, active high
  input  wire logic msTick,   // one-cycle millisecond enable
  cfm_loss_if.det   lif       // settings and status
);
  import cfm_pkg::*;

  cfm_clk_e    state_reg, state_next;
  logic [15:0] gap_reg, gap_next;
  logic [7:0]  miss_reg, miss_next;
  logic [9:0]  qual_reg, qual_next;
  logic [16:0] gapInc;

  assign gapInc = {1'b0, gap_reg} + 17'h00001;

  // gap and missing-edge counting, then loss state
  always_comb begin
    gap_next   = gapInc[15:0];
    miss_next  = miss_reg;
    state_next = state_reg;
    qual_next  = qual_reg;
    if (lif.edgeSeen) begin
      gap_next  = 16'h0000;
      miss_next = 8'h00;
    end else if (gapInc >= {1'b0, lif.period}) begin
      gap_next = 16'h0000;
      // saturate so a dead clock never wraps back to healthy
      if (miss_reg != 8'hff) begin
        miss_next = miss_reg + 8'h01;
      end
    end
    unique case (state_reg)
      CLK_OK: begin
        if (lif.setCnt != 8'h00 && miss_next >= lif.setCnt) begin
          state_next = CLK_LOST;
        end
      end
      CLK_LOST: begin
        if (lif.edgeSeen) begin
          state_next = CLK_QUAL;
          qual_next  = 10'h000;
        end
      end
      CLK_QUAL: begin
        if (miss_next >= {2'b00, lif.clrCnt}) begin
          state_next = CLK_LOST;
        end else if (msTick) begin
          if (qual_reg + 10'h001 >= VAL_MS[lif.valSel]) begin
            state_next = CLK_OK;
          end else begin
            qual_next = qual_reg + 10'h001;
          end
        end
      end
      default: state_next = CLK_LOST;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= CLK_OK;
      gap_reg   <= 16'h0000;
      miss_reg  <= 8'h00;
      qual_reg  <= 10'h000;
    end else begin
      state_reg <= state_next;
      gap_reg   <= gap_next;
      miss_reg  <= miss_next;
      qual_reg  <= qual_next;
    end
  end

  assign lif.lost = (state_reg != CLK_OK);
endmodule : cfm_loss_det
`default_nettype wire

// file: core/cfm_clock_fault_monitor.sv
// clock loss and pll drift monitor with sticky bits, alarms and interrupt
// Summary of operation
// - live active-high status per defect
// - sticky bit latches first defect, holds
// - sticky latching enabled per defect
// - alarm pin: one bit or OR
// - selected sticky bits pull interrupt low
// - monitors use predivided input clocks
// - four independent loss detectors, own settings
// - returned when missing below clear count
// - qualify 2m/100m/200m/1s, loss restarts
// - per pll reference versus feedback frequency
// - drift set thresholds 0.2 to 4000ppm
// - drift clear thresholds give hysteresis
// - drift clears only after settling timer
// - live and sticky readable and pinned
// - pll picks best input not lost
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cfm_clock_fault_monitor #(
  parameter int TICK_CYCLES = cfm_pkg::TICK_CYC  // cycles per ms tick
) (
  input  wire logic                         ref_clk,    // 200 MHz clock
  input  wire logic                         rst,        // async reset
  input  wire logic [cfm_pkg::NUM_IN-1:0]   inClk,      // predivided inputs
  input  wire logic [cfm_pkg::NUM_PLL-1:0]  fbClk,      // pll feedback
  input  wire logic [cfm_pkg::ADDR_W-1:0]   regAddr,    // byte address
  input  wire logic [31:0]                  regWrData,  // write data
  input  wire logic                         regWr,      // write strobe
  input  wire logic                         regRd,      // read strobe
  output logic      [31:0]                  regRdData,  // read data
  output logic [cfm_pkg::NUM_ALARM-1:0] configurableAlarmPin, // alarms
  output logic                              alarmInterruptN // irq, low
);
  import cfm_pkg::*;

  localparam int NSYNC = NUM_IN + NUM_PLL;

  // synchroniser and edge detect for inputs and feedbacks
  logic [NSYNC-1:0] meta_reg, sync_reg, dly_reg;
  logic [NSYNC-1:0] rise;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      dly_reg  <= '0;
    end else begin
      meta_reg <= {fbClk, inClk};
      sync_reg <= meta_reg;
      dly_reg  <= sync_reg;
    end
  end
  assign rise = sync_reg & ~dly_reg;

  // millisecond enable from a free-running divider
  logic [31:0] tick_reg, tick_next;
  logic        msTick;
  always_comb begin
    tick_next = tick_reg + 32'h1;
    if (tick_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_next = 32'h0;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_next;
    end
  end
  assign msTick = (tick_reg == 32'(TICK_CYCLES - 1));

  // software-owned settings
  logic [31:0] lossCfg_reg   [NUM_IN];
  logic [31:0] lossCfg_next  [NUM_IN];
  logic [31:0] driftCfg_reg  [NUM_PLL];
  logic [31:0] driftCfg_next [NUM_PLL];
  logic [31:0] alm_reg       [NUM_ALARM];
  logic [31:0] alm_next      [NUM_ALARM];
  logic [7:0]  en_reg, en_next, mask_reg, mask_next;
  logic [7:0]  notify_reg, notify_next, live;
  logic [1:0]  idx;
  logic        wordOk;
  assign idx    = regAddr[3:2];
  assign wordOk = (regAddr[1:0] == 2'b00);

  always_comb begin
    lossCfg_next  = lossCfg_reg;
    driftCfg_next = driftCfg_reg;
    alm_next   = alm_reg;
    en_next    = en_reg;
    mask_next  = mask_reg;
    if (regWr && wordOk) begin
      if (regAddr == OFS_NOTIFY_EN) begin
        en_next = regWrData[7:0];
      end
      if (regAddr == OFS_INT_MASK) begin
        mask_next = regWrData[7:0];
      end
      if (regAddr[6:4] == OFS_LOSS_CFG[6:4]) begin
        lossCfg_next[idx] = regWrData & LOSS_CFG_WMASK;
      end
      if (regAddr[6:4] == OFS_DRIFT_CFG[6:4]) begin
        driftCfg_next[idx] = regWrData & DRIFT_CFG_WMASK;
      end
      if (regAddr[6:4] == OFS_ALM_CFG[6:4]) begin
        alm_next[idx] = regWrData & ALM_WMASK;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lossCfg_reg  <= '{default: LOSS_CFG_RST};
      driftCfg_reg <= '{default: DRIFT_CFG_RST};
      alm_reg      <= '{default: ALM_RST};
      en_reg    <= DEF_RST;
      mask_reg  <= DEF_RST;
    end else begin
      lossCfg_reg  <= lossCfg_next;
      driftCfg_reg <= driftCfg_next;
      alm_reg      <= alm_next;
      en_reg    <= en_next;
      mask_reg  <= mask_next;
    end
  end

  logic [NUM_IN-1:0] inLost;
  for (genvar k = 0; k < NUM_IN; k++) begin : g_in
    cfm_loss_if lif ();
    assign lif.period   = lossCfg_reg[k][LOSS_PERIOD_LSB +: 16];
    assign lif.setCnt   = lossCfg_reg[k][LOSS_SET_LSB +: 8];
    assign lif.clrCnt   = lossCfg_reg[k][LOSS_CLR_LSB +: 6];
    assign lif.valSel   = lossCfg_reg[k][LOSS_VAL_LSB +: 2];
    assign lif.edgeSeen = rise[k];
    assign inLost[k]    = lif.lost;
    cfm_loss_det u_det (
      .ref_clk (ref_clk),
      .rst     (rst),
      .msTick  (msTick),
      .lif     (lif.det)
    );
  end

  // per pll: reference choice and drift measurement
  logic [NUM_PLL-1:0] pllLost, selValid;
  logic [1:0]         selIn [NUM_PLL];
  for (genvar p = 0; p < NUM_PLL; p++) begin : g_pll
    cfm_lock_e   st_reg, st_next;
    logic [23:0] refCnt_reg, refCnt_next, fbCnt_reg, fbCnt_next;
    logic [15:0] settle_reg, settle_next;
    logic [7:0]  prio;
    logic [3:0]  setSel;
    logic [15:0] setThr, clrThr, settleMs;
    logic [23:0] diff;
    logic [63:0] scaled;
    logic        refEdge, overSet, underClr;

    assign prio     = driftCfg_reg[p][DRIFT_PRIO_LSB +: 8];
    assign setSel   = driftCfg_reg[p][DRIFT_SET_LSB +: 4];
    assign settleMs = driftCfg_reg[p][DRIFT_SETTLE_LSB +: 16];
    assign setThr   = SET_DPPM[(setSel > 4'd9) ? 4'd9 : setSel];
    assign clrThr   = CLR_DPPM[driftCfg_reg[p][DRIFT_CLR_LSB +: 2]];

    always_comb begin
      selIn[p]    = prio[1:0];
      selValid[p] = 1'b0;
      for (int e = NUM_IN - 1; e >= 0; e--) begin
        if (!inLost[prio[2*e +: 2]]) begin
          selIn[p]    = prio[2*e +: 2];
          selValid[p] = 1'b1;
        end
      end
    end
    assign refEdge = selValid[p] & rise[selIn[p]];

    assign diff   = (refCnt_reg > fbCnt_reg) ? refCnt_reg - fbCnt_reg
                                             : fbCnt_reg - refCnt_reg;
    assign scaled = 64'(diff) * PPM_SCALE;
    assign overSet  = (refCnt_reg == 24'h0) ||
                      (scaled > 64'(setThr) * 64'(refCnt_reg));
    assign underClr = (refCnt_reg != 24'h0) &&
                      (scaled < 64'(clrThr) * 64'(refCnt_reg));

    always_comb begin
      refCnt_next = refCnt_reg + {23'h0, refEdge};
      fbCnt_next  = fbCnt_reg + {23'h0, rise[NUM_IN + p]};
      st_next     = st_reg;
      settle_next = settle_reg;
      if (msTick) begin
        // gate window closes every tick
        refCnt_next = {23'h0, refEdge};
        fbCnt_next  = {23'h0, rise[NUM_IN + p]};
        unique case (st_reg)
          LK_OK: begin
            if (overSet) begin
              st_next = LK_LOST;
            end
          end
          LK_LOST: begin
            if (underClr) begin
              st_next     = LK_SETTLE;
              settle_next = 16'h0000;
            end
          end
          LK_SETTLE: begin
            if (!underClr) begin
              st_next = LK_LOST;
            end else if (settle_reg + 16'h0001 >= settleMs) begin
              st_next = LK_OK;
            end else begin
              settle_next = settle_reg + 16'h0001;
            end
          end
          default: st_next = LK_LOST;
        endcase
      end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        st_reg     <= LK_OK;
        refCnt_reg <= 24'h0;
        fbCnt_reg  <= 24'h0;
        settle_reg <= 16'h0000;
      end else begin
        st_reg     <= st_next;
        refCnt_reg <= refCnt_next;
        fbCnt_reg  <= fbCnt_next;
        settle_reg <= settle_next;
      end
    end
    assign pllLost[p] = (st_reg != LK_OK);
  end

  assign live = {pllLost, inLost};

  // sticky bits, alarm pins, interrupt and read port
  logic [NUM_ALARM-1:0] alarm_next;
  logic [31:0]          rd_next;
  logic [7:0]           selWord;
  always_comb begin
    logic [7:0] src;
    src     = 8'h00;
    selWord = {selIn[3], selIn[2], selIn[1], selIn[0]};
    notify_next = notify_reg;
    if (regWr && regAddr == OFS_NOTIFY) begin
      notify_next = notify_reg & ~regWrData[7:0];
    end
    notify_next = notify_next | (live & en_reg);
    for (int j = 0; j < NUM_ALARM; j++) begin
      src = alm_reg[j][ALM_LIVE_BIT] ? live : notify_reg;
      if (alm_reg[j][ALM_OR_BIT]) begin
        alarm_next[j] = |(src & alm_reg[j][ALM_MASK_LSB +: 8]);
      end else begin
        alarm_next[j] = src[alm_reg[j][ALM_SEL_LSB +: 3]];
      end
    end
    rd_next = 32'h0;
    if (regRd && wordOk) begin
      unique case (regAddr[6:4])
        OFS_STATUS[6:4]: begin
          unique case (regAddr[3:2])
            OFS_STATUS[3:2]:    rd_next = {24'h0, live};
            OFS_NOTIFY[3:2]:    rd_next = {24'h0, notify_reg};
            OFS_NOTIFY_EN[3:2]: rd_next = {24'h0, en_reg};
            OFS_INT_MASK[3:2]:  rd_next = {24'h0, mask_reg};
          endcase
        end
        OFS_LOSS_CFG[6:4]:  rd_next = lossCfg_reg[idx];
        OFS_DRIFT_CFG[6:4]: rd_next = driftCfg_reg[idx];
        OFS_ALM_CFG[6:4]: rd_next = alm_reg[idx];
        OFS_SEL[6:4]: begin
          if (regAddr[3:2] == OFS_SEL[3:2]) begin
            rd_next = {20'h0, selValid, selWord};
          end
        end
        default: rd_next = 32'h0;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      notify_reg           <= DEF_RST;
      configurableAlarmPin <= '0;
      alarmInterruptN      <= 1'b1;
      regRdData            <= 32'h0;
    end else begin
      notify_reg           <= notify_next;
      configurableAlarmPin <= alarm_next;
      alarmInterruptN      <= ~|(notify_next & mask_reg);
      regRdData            <= rd_next;
    end
  end
endmodule : cfm_clock_fault_monitor
`default_nettype wire

// file: verif/cfm_clk_src.sv
// stand-in for the predivided clock sources and pll feedback
`timescale 1ns/1ps
`default_nettype none
module cfm_clk_src (
  input  wire logic [3:0] inRun,  // per input: clock present
  input  wire logic [3:0] fbRun,  // per pll: feedback present
  output logic      [3:0] inClk,  // predivided input clocks
  output logic      [3:0] fbClk   // divided feedback clocks
);
  logic base = 1'b0;  // common 25 MHz source
  // one source for all, so every pll sits at zero drift
  always #20 base = ~base;
  // feedback as the pll sees it
  // a stopped clock rests low, like a dead driver
  assign inClk = inRun & {4{base}};
  assign fbClk = fbRun & {4{base}};
endmodule : cfm_clk_src
`default_nettype wire

// file: verif/cfm_monitor_assertions.sv
// port checker of the clock fault monitor
`timescale 1ns/1ps
`default_nettype none
module cfm_monitor_assertions
  import cfm_pkg::*;
#(
  parameter int TICK_CYCLES = 200  // cycles per ms tick
) (
  input wire logic                 ref_clk,              // clock
  input wire logic                 rst,                  // async reset
  input wire logic [NUM_IN-1:0]    inClk,                // inputs
  input wire logic [NUM_PLL-1:0]   fbClk,                // feedback
  input wire logic [ADDR_W-1:0]    regAddr,              // address
  input wire logic [31:0]          regWrData,            // write data
  input wire logic                 regWr,                // write strobe
  input wire logic                 regRd,                // read strobe
  input wire logic [31:0]          regRdData,            // read data
  input wire logic [NUM_ALARM-1:0] configurableAlarmPin, // alarms
  input wire logic                 alarmInterruptN       // irq, low
);
  logic [7:0] maskReg;   // shadow of the interrupt mask
  logic [7:0] maskNext;  // its next value
  // follow software writes to the mask
  always_comb begin
    maskNext = maskReg;
    if (regWr && regAddr == OFS_INT_MASK) maskNext = regWrData[7:0];
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) maskReg <= 8'h00;
    else maskReg <= maskNext;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_rd_idle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_rd_misalign;
    regRd && regAddr[1:0] != 2'b00 |=> regRdData == 32'h0;
  endproperty
  a_rd_misalign: assert property (p_rd_misalign)
    else $error("misaligned read not zero");
  property p_status_upper;
    regRd && regAddr == OFS_STATUS |=> regRdData[31:8] == 24'h0;
  endproperty
  a_status_upper: assert property (p_status_upper)
    else $error("status upper bits set");
  property p_cfg_echo;
    regWr && regAddr == OFS_LOSS_CFG ##2 regRd && regAddr == OFS_LOSS_CFG
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_cfg_echo: assert property (p_cfg_echo)
    else $error("loss setting not kept");
  // back-to-back reads with no write between may only gain bits
  property p_notify_stick;
    regRd && regAddr == OFS_NOTIFY ##1 regRd && regAddr == OFS_NOTIFY
      |=> (regRdData & $past(regRdData)) == $past(regRdData);
  endproperty
  a_notify_stick: assert property (p_notify_stick)
    else $error("sticky bit lost without clear");
  property p_irq_rst;
    $past(rst) |-> alarmInterruptN && configurableAlarmPin == '0;
  endproperty
  a_irq_rst: assert property (p_irq_rst)
    else $error("pins not idle after reset");
  property p_irq_notify;
    regRd && regAddr == OFS_NOTIFY ##1 (regRdData[7:0] & maskReg) != 8'h0
      |-> !alarmInterruptN;
  endproperty
  a_irq_notify: assert property (p_irq_notify)
    else $error("unmasked sticky bit without irq");
  property p_irq_mask;
    $past(maskReg) == 8'h0 && maskReg == 8'h0 |-> alarmInterruptN;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with empty mask");
  property p_sel_upper;
    regRd && regAddr == OFS_SEL |=> regRdData[31:12] == 20'h0;
  endproperty
  a_sel_upper: assert property (p_sel_upper)
    else $error("selection upper bits set");
endmodule : cfm_monitor_assertions

bind cfm_clock_fault_monitor cfm_monitor_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) cfm_monitor_assertions_inst (
  .ref_clk(ref_clk),
  .rst(rst),
  .inClk(inClk),
  .fbClk(fbClk),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWr(regWr),
  .regRd(regRd),
  .regRdData(regRdData),
  .configurableAlarmPin(configurableAlarmPin),
  .alarmInterruptN(alarmInterruptN)
);
`default_nettype wire

// file: verif/cfm_clock_fault_monitor_tb.sv
// self-checking bench of the clock fault monitor
`timescale 1ns/1ps
`default_nettype none
module cfm_clock_fault_monitor_tb;
  import cfm_pkg::*;
  localparam int TICK = 200;  // short ms tick keeps the run brief
  logic              ref_clk, rst, regWr, regRd, intN;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData, regRdData, d0, d1;
  logic [3:0]        inClk, fbClk, inRun, fbRun, pins;
  int                n_fail, tests_run;

  cfm_clock_fault_monitor #(.TICK_CYCLES(TICK)) cfm_clock_fault_monitor_inst (
    .ref_clk(ref_clk), .rst(rst), .inClk(inClk), .fbClk(fbClk),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData),
    .configurableAlarmPin(pins), .alarmInterruptN(intN));
  cfm_clk_src cfm_clk_src_inst (
    .inRun(inRun), .fbRun(fbRun), .inClk(inClk), .fbClk(fbClk));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk
  // bus tasks start and end just after a rising edge
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    // one idle edge, so a following write never reassigns the strobe
    @(posedge ref_clk);
  endtask : wr
  // two reads when twice is set, back to back
  task automatic rd(input logic [6:0] a, output logic [31:0] d,
                    input bit twice = 0);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    if (twice) begin
      @(negedge ref_clk);
      d1 = regRdData;
      @(posedge ref_clk);
    end
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
    @(posedge ref_clk);
  endtask : rd
  // poll one status bit, bounded
  task automatic wait_bit(input int b, input logic v);
    logic [31:0] s;
    for (int i = 0; i < 400; i++) begin
      rd(OFS_STATUS, s);
      if (s[b] === v) return;
    end
    n_fail++;
    $display("unexpected status bit %0d: expected %b, seen %b", b, v, s[b]);
    report_and_stop();
  endtask : wait_bit
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_reset_map();
    rd(OFS_STATUS, d0);
    chk("status", 32'h0, d0);
    rd(OFS_LOSS_CFG + 7'h0c, d0);
    chk("loss cfg 3", LOSS_CFG_RST, d0);
    rd(OFS_DRIFT_CFG + 7'h04, d0);
    chk("drift cfg 1", DRIFT_CFG_RST, d0);
    rd(7'h7c, d0);
    chk("unmapped", 32'h0, d0);
    rd(7'h11, d0);
    chk("misaligned", 32'h0, d0);
    rd(OFS_SEL, d0);
    chk("selection", 32'h00000f00, d0);
    chk("pins", 32'h0, {28'h0, pins});
    chk("irq", 32'h1, {31'h0, intN});
    // period 16 cycles, settle 2 ms, so tests stay short
    for (int k = 3; k >= 0; k--) begin
      wr(OFS_DRIFT_CFG + 7'(4 * k), 32'h390000b9);
      wr(OFS_LOSS_CFG + 7'(4 * k), 32'h02040010);
    end
    rd(OFS_LOSS_CFG, d0);
    chk("loss cfg 0", 32'h02040010, d0);
    wr(OFS_NOTIFY_EN, 32'h05);
    wr(OFS_INT_MASK, 32'h01);
    wr(OFS_ALM_CFG + 7'h04, 32'h806);
    wr(OFS_ALM_CFG + 7'h08, 32'h1100);
    $display("reset and map done");
  endtask : t_reset_map

  task automatic t_loss();
    inRun <= 4'b1110;
    wait_bit(0, 1'b1);
    rd(OFS_SEL, d0);
    chk("pll0 input", 32'h1, d0 & 32'h3);
    rd(OFS_NOTIFY, d0);
    chk("sticky", 32'h1, d0);
    chk("pins", 32'h9, {28'h0, pins});
    chk("irq", 32'h0, {31'h0, intN});
    inRun <= 4'b1111;
    rd(OFS_STATUS, d0);
    chk("qualifying", 32'h1, d0 & 32'hf);
    wait_bit(0, 1'b0);
    rd(OFS_NOTIFY, d0, 1);
    chk("sticky first", 32'h1, d1);
    chk("sticky kept", 32'h1, d0);
    wr(OFS_NOTIFY, 32'h1);
    rd(OFS_NOTIFY, d0);
    chk("cleared", 32'h0, d0);
    chk("irq off", 32'h1, {31'h0, intN});
    $display("clock loss done");
  endtask : t_loss

  task automatic t_sticky_off();
    inRun <= 4'b1001;
    wait_bit(1, 1'b1);
    wait_bit(2, 1'b1);
    rd(OFS_NOTIFY, d0);
    chk("enable", 32'h4, d0);
    chk("pins", 32'h6, {28'h0, pins});
    chk("irq masked", 32'h1, {31'h0, intN});
    inRun <= 4'b1111;
    wait_bit(1, 1'b0);
    wait_bit(2, 1'b0);
    chk("pins", 32'h2, {28'h0, pins});
    wr(OFS_NOTIFY, 32'hff);
    $display("sticky enable done");
  endtask : t_sticky_off

  task automatic t_drift();
    for (int k = 4; k < 8; k++) wait_bit(k, 1'b0);
    fbRun <= 4'b1110;
    wait_bit(4, 1'b1);
    rd(OFS_STATUS, d0);
    chk("drift", 32'h10, d0);
    fbRun <= 4'b1111;
    // clear met within two ticks, settling timer still holds the alarm
    repeat (420) @(posedge ref_clk);
    rd(OFS_STATUS, d0);
    chk("settling", 32'h10, d0);
    wait_bit(4, 1'b0);
    $display("drift done");
  endtask : t_drift

  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = '0;
    inRun = 4'hf;
    fbRun = 4'hf;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_map();
    t_loss();
    t_sticky_off();
    t_drift();
    report_and_stop();
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
endmodule : cfm_clock_fault_monitor_tb
`default_nettype wire
